// ### bench/flash_host_model.sv
/*
  Host side of the flash bus: asynchronous write and read cycles.
  Assumes the caller's clock; write strobe phases span six cycles, the read strobe eight low and five high.
*/
`default_nettype none
module flash_host_model (
  input wire logic clk, // Bench clock
  output logic ce_n, // Chip enable
  output logic we_n, // Write strobe
  output logic oe_n, // Output enable
  output logic [23:0] addr, // Word address
  output logic [15:0] dq, // Write data
  input wire logic [15:0] dq_out, // Read data
  input wire logic dq_oe // Read data driven
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ce_n = 1'b1;
    we_n = 1'b1;
    oe_n = 1'b1;
    addr = 24'h000000;
    dq = 16'h0000;
  end
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    dq = d;
    ce_n = 1'b0;
    we_n = 1'b0;
    repeat (6) @(negedge clk);
    ce_n = 1'b1;
    we_n = 1'b1;
    repeat (6) @(negedge clk);
    dq = ~d; // Released lines show no stale value
  endtask : wr
  task automatic rd(input logic [23:0] a, output logic [15:0] d, output logic oe);
    @(negedge clk);
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    repeat (8) @(negedge clk);
    d = dq_out;
    oe = dq_oe;
    ce_n = 1'b1;
    oe_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask : rd
endmodule : flash_host_model
`default_nettype wire

// ### bench/flash_status_checker.sv
/*
  Port-level assertions on the flash command decoder and status word.
  Assumes array read data keeps bits 15:10 low and bits 7 and 0 high.
*/
`include "flash_cmd_params.svh"
`default_nettype none
module flash_status_checker #(
  parameter int unsigned PROG_CYCLES = 4,
  parameter int unsigned ERASE_CYCLES = 8,
  parameter int unsigned BLANK_CYCLES = 4
) (
  input wire logic SYS_CLK, // Clock
  input wire logic RSTN, // Reset, active low
  input wire logic CE_N, // Chip enable pin
  input wire logic WE_N, // Write strobe pin
  input wire logic OE_N, // Output enable pin
  input wire logic [15:0] DQ_OUT, // Read data
  input wire logic DQ_OE, // Data pins driven
  input wire logic READY // Device ready
);
  logic [3:0] oe_age;
  logic [3:0] we_age;
  logic [15:0] prev_st;
  logic prev_ok;
  // Status shown: array data always has bits 7 and 0 both set
  wire logic is_st = DQ_OE && !(DQ_OUT[7] && DQ_OUT[0]);
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      oe_age <= 4'hf;
      we_age <= 4'hf;
      prev_ok <= 1'b0;
      prev_st <= 16'h0080;
    end else begin
      oe_age <= !OE_N ? 4'h0 : (oe_age == 4'hf ? oe_age : oe_age + 4'h1);
      we_age <= !WE_N ? 4'h0 : (we_age == 4'hf ? we_age : we_age + 4'h1);
      prev_ok <= is_st;
      prev_st <= DQ_OUT;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  chk_reset_ready_word: assert property ($rose(RSTN) |-> READY && DQ_OUT == 16'h0080 && !DQ_OE)
    else $error("reset value wrong");
  chk_high_bits_zero: assert property (DQ_OE |-> DQ_OUT[15:10] == 6'h00)
    else $error("status bits 15:10 not zero");
  chk_ready_bit_match: assert property (is_st && $stable(READY) && $past(READY, 2) == READY |-> DQ_OUT[7] == READY)
    else $error("ready bit disagrees with READY");
  chk_busy_after_write: assert property ($fell(READY) |-> we_age <= 4'ha)
    else $error("busy without a write");
  chk_read_drives_bus: assert property ((!CE_N && !OE_N && WE_N) [*7] |-> DQ_OE)
    else $error("read not answered");
  chk_drive_needs_read: assert property (DQ_OE |-> oe_age <= 4'h7)
    else $error("bus driven without read");
  chk_write_no_drive: assert property ((!CE_N && !WE_N) [*6] |-> !DQ_OE)
    else $error("bus driven during write");
  chk_errors_sticky: assert property (prev_ok && is_st && we_age > 4'h9 |->
    ((prev_st & ~DQ_OUT) & `SR_ERROR_MASK) == 16'h0000)
    else $error("error bit cleared without command");
endmodule : flash_status_checker

bind flash_command_status_unit flash_status_checker #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES),
  .BLANK_CYCLES(BLANK_CYCLES)) chk_u (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .CE_N(CE_N), .WE_N(WE_N), .OE_N(OE_N),
  .DQ_OUT(DQ_OUT), .DQ_OE(DQ_OE), .READY(READY));
`default_nettype wire

// ### bench/tb_flash_command_status_unit.sv
/*
  Self-checking bench of the flash command decoder and status word.
  Assumes the host model for bus cycles and shortened operation lengths.
*/
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_flash_command_status_unit;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] pa0 = 24'h000000;
  localparam logic [23:0] pa1 = 24'h200000;
  localparam logic [23:0] pa2 = 24'h400000;
  localparam logic [23:0] pa3 = 24'h600000;
  localparam logic [23:0] blk_b = 24'h020000;
  localparam logic [23:0] blk_c = 24'h040000;
  localparam logic [23:0] blk_d = 24'h060000;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic vpp_low = 1'b0;
  logic array_blank = 1'b1;
  logic [1:0] region_err = 2'b00;
  logic ce_n, we_n, oe_n, dq_oe, ready;
  logic [23:0] addr;
  logic [15:0] dq_in, dq_out;
  int err_total = 0;
  int check_count = 0;
  always #25 sys_clk = ~sys_clk;
  flash_command_status_unit #(.PROG_CYCLES(20), .ERASE_CYCLES(40), .BLANK_CYCLES(20)) dut_u (
    .SYS_CLK(sys_clk), .RSTN(rstn), .CLK_EN(1'b1), .CE_N(ce_n), .WE_N(we_n), .OE_N(oe_n), .ADDR(addr),
    .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe), .VPP_LOW(vpp_low), .ARRAY_BLANK(array_blank),
    .REGION_ERR(region_err), .ARRAY_RDATA(16'h00ff), .READY(ready));
  flash_host_model host_u (.clk(sys_clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(addr), .dq(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    host_u.wr(a, d);
  endtask : wr
  task automatic rd(input string n, input logic [23:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic oe;
    host_u.rd(a, d, oe);
    `CHK("bus driven", 1'b1, oe)
    `CHK(n, e, d)
  endtask : rd
  task automatic wait_ready;
    for (int i = 0; i < 400 && ready !== 1'b1; i++) @(negedge sys_clk);
    if (ready !== 1'b1) begin
      err_total++;
      $display("[ERR] ready exp 1 got %b", ready);
      conclude();
    end
  endtask : wait_ready
  // Setup, confirm, wait, then status read of the same partition
  task automatic op_chk(input string n, input logic [23:0] a, input logic [15:0] s, input logic [15:0] e);
    wr(a, s);
    wr(a, 16'h00d0);
    wait_ready();
    rd(n, a, e);
  endtask : op_chk
  initial begin
    repeat (8) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK("ready", 1'b1, ready)
    wr(pa0, 16'h0070);
    rd("status reset", pa0, 16'h0080);
    wr(pa0, 16'h00ff);
    rd("array", pa0, 16'h00ff);
    wr(pa1, 16'h0070);
    wr(pa0, 16'h0020);
    rd("between", pa0, 16'h00ff);
    wr(pa0, 16'h00d0);
    `CHK("erase busy", 1'b0, ready)
    rd("own part", pa0, 16'h0000);
    rd("other part", pa1, 16'h0001);
    wait_ready();
    rd("erase done", pa0, 16'h0080);
    wr(pa0, 16'h0020);
    wr(pa0, 16'h00d0);
    wr(pa3, 16'h00b0);
    wait_ready();
    rd("suspended", pa0, 16'h00c0);
    wr(pa0, 16'h0050);
    rd("suspend kept", pa0, 16'h00c0);
    wr(blk_c, 16'h0080);
    wr(blk_c, 16'h00d0);
    wr(blk_c, 16'h1234);
    wr(pa3, 16'h00b0);
    rd("nested", pa0, 16'h00c4);
    wr(pa3, 16'h00d0);
    wait_ready();
    rd("program first", pa0, 16'h00c0);
    wr(pa3, 16'h00d0);
    `CHK("resumed", 1'b0, ready)
    wait_ready();
    rd("resume done", pa0, 16'h0080);
    wr(blk_b, 16'h0060);
    wr(blk_b, 16'h0001);
    op_chk("locked", blk_b, 16'h0020, 16'h00a2);
    wr(pa0, 16'h0050);
    wr(blk_b, 16'h0060);
    wr(blk_b, 16'h00d0);
    op_chk("unlocked", blk_b, 16'h0020, 16'h0080);
    wr(blk_b, 16'h0060);
    wr(blk_b, 16'h002f);
    wr(blk_b, 16'h0060);
    wr(blk_b, 16'h00d0);
    op_chk("locked down", blk_b, 16'h0020, 16'h00a2);
    wr(pa0, 16'h0050);
    vpp_low = 1'b1;
    op_chk("supply", pa0, 16'h0020, 16'h00a8);
    wr(pa0, 16'h00ff);
    wr(pa0, 16'h0050);
    rd("cleared", pa0, 16'h0080);
    rd("other mode", pa2, 16'h00ff);
    vpp_low = 1'b0;
    wr(pa0, 16'h0020);
    wr(pa0, 16'h00d0);
    vpp_low = 1'b1;
    wait_ready();
    rd("supply drop", pa0, 16'h00a8);
    wr(pa0, 16'h0050);
    vpp_low = 1'b0;
    wr(pa0, 16'h0020);
    wr(pa0, 16'h0070);
    rd("write between", pa0, 16'h00b0);
    wr(pa0, 16'h0050);
    wr(pa0, 16'h0060);
    wr(pa0, 16'h0055);
    rd("bad confirm", pa0, 16'h00b0);
    wr(pa0, 16'h00ff);
    wr(pa0, 16'h0070);
    rd("sticky", pa0, 16'h00b0);
    wr(pa0, 16'h0050);
    array_blank = 1'b0;
    op_chk("not blank", blk_c, 16'h00bc, 16'h00a0);
    wr(pa0, 16'h0050);
    array_blank = 1'b1;
    op_chk("blank", blk_c, 16'h00bc, 16'h0080);
    region_err = 2'b10;
    wr(blk_c, 16'h0080);
    wr(blk_c, 16'h00d0);
    `CHK("factory mode", 1'b0, ready)
    wr(blk_c, 16'h1234);
    rd("word busy", blk_c, 16'h0001);
    repeat (30) @(negedge sys_clk);
    wr(blk_d, 16'h5678);
    wait_ready();
    rd("region", blk_c, 16'h0290);
    region_err = 2'b00;
    wr(pa0, 16'h0020);
    wr(pa0, 16'h00d0);
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    `CHK("reset ready", 1'b1, ready)
    rstn = 1'b1;
    repeat (8) @(negedge sys_clk);
    wr(pa0, 16'h0070);
    rd("after reset", pa0, 16'h0080);
    conclude();
  end
endmodule : tb_flash_command_status_unit
`default_nettype wire

// ### logic/flash_command_status_unit.sv
/*
  Command decoder, operation sequencer and status word of a partitioned
  NOR flash. Bus pins are asynchronous and pass the three-stage filter.
  Assumes the array core returns blank and region results on the same clock.
*/
`include "flash_cmd_params.svh"
`default_nettype none
module flash_command_status_unit
  import flash_cmd_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES,
  parameter int unsigned ERASE_CYCLES = `ERASE_CYCLES,
  parameter int unsigned BLANK_CYCLES = `BLANK_CYCLES
) (
  input wire logic SYS_CLK, // 20 MHz clock
  input wire logic RSTN, // Asynchronous reset, active low
  input wire logic CLK_EN, // Freezes all state but the reset synchroniser when low
  input wire logic CE_N, // Chip enable pin, active low
  input wire logic WE_N, // Write strobe pin, active low
  input wire logic OE_N, // Output enable pin, active low
  input wire logic [`ADDR_W-1:0] ADDR, // Address pins
  input wire logic [15:0] DQ_IN, // Data pins, input side
  output logic [15:0] DQ_OUT, // Data pins, output side
  output logic DQ_OE, // Data pins driven when high
  input wire logic VPP_LOW, // Supply below lockout threshold
  input wire logic ARRAY_BLANK, // Addressed block reads blank
  input wire logic [1:0] REGION_ERR, // Region result of last word
  input wire logic [15:0] ARRAY_RDATA, // Array read data
  output logic READY // Device ready
);
  logic rst_s1;
  logic rst_n;
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // Pin filter
  localparam int SW = 4 + `ADDR_W + 16;
  logic [SW-1:0] pins_q;
  pin_sync #(.W(SW), .INIT({4'b1110, {(`ADDR_W + 16){1'b0}}})) u_sync (
    .clk(SYS_CLK),
    .rst_n(rst_n),
    .clk_en(CLK_EN),
    .d({CE_N, WE_N, OE_N, VPP_LOW, ADDR, DQ_IN}),
    .q(pins_q)
  );
  wire ce_n_s = pins_q[SW-1];
  wire we_n_s = pins_q[SW-2];
  wire oe_n_s = pins_q[SW-3];
  wire vpp_low_s = pins_q[SW-4];
  wire [`ADDR_W-1:0] addr_s = pins_q[`ADDR_W+15:16];
  wire [15:0] data_s = pins_q[15:0];

  function automatic logic [6:0] blk_of(input logic [`ADDR_W-1:0] a);
    return a[`BLK_HI:`BLK_LO];
  endfunction : blk_of
  function automatic logic [2:0] part_of(input logic [`ADDR_W-1:0] a);
    return a[`PART_HI:`PART_LO];
  endfunction : part_of

  // Write cycle capture: latched on the first rising strobe
  logic wr_act_d;
  logic [`ADDR_W-1:0] cap_addr;
  logic [15:0] cap_data;
  wire wr_act = !ce_n_s && !we_n_s;
  wire wr = wr_act_d && !wr_act; // R24
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_act_d <= 1'b0;
      cap_addr <= '0;
      cap_data <= '0;
    end else if (CLK_EN) begin
      wr_act_d <= wr_act;
      if (wr_act) begin
        cap_addr <= addr_s;
        cap_data <= data_s;
      end
    end
  end
  wire [6:0] wr_blk = blk_of(cap_addr);
  wire [2:0] wr_part = part_of(cap_addr);

  // State
  cmd_state_t cmd_state;
  logic [15:0] setup_code;
  logic [6:0] setup_blk;
  op_kind_t run_kind;
  logic [15:0] run_cnt;
  logic [6:0] run_blk;
  logic erase_parked;
  logic [15:0] erase_left;
  logic [6:0] erase_blk;
  logic prog_parked;
  logic [15:0] prog_left;
  logic [6:0] prog_blk;
  logic [15:0] err;
  logic [7:0] mode_status;
  logic [127:0] lock_bit;
  logic [127:0] lockdown_bit;

  cmd_state_t next_cmd_state;
  op_kind_t next_run_kind;
  logic [15:0] next_run_cnt;
  logic [6:0] next_run_blk;
  logic next_erase_parked;
  logic [15:0] next_erase_left;
  logic next_prog_parked;
  logic [15:0] next_prog_left;
  logic [15:0] err_set;
  logic err_clr;
  logic [7:0] next_mode_status;
  logic [127:0] next_lock_bit;
  logic [127:0] next_lockdown_bit;

  wire running = run_kind != OP_NONE;
  wire is_setup = cap_data == `CODE_BUFFERED_FACTORY_PROGRAMMING_SETUP || cap_data == `CODE_ERASE_SETUP ||
                  cap_data == `CODE_LOCK_SETUP || cap_data == `CODE_BLANK_SETUP;
  wire is_confirm = cap_data == `CODE_CONFIRM;
  wire [15:0] seq_err = 16'h0030;
  wire [15:0] prog_fail = 16'h0010;
  wire [15:0] erase_fail = 16'h0020;

  // Start check for an array operation on a block
  function automatic logic [15:0] start_err(input op_kind_t k, input logic locked,
                                            input logic vpp_low);
    logic [15:0] e;
    e = '0;
    if (locked && k != OP_BLANK) begin
      e = (k == OP_PROG) ? 16'h0012 : 16'h0022; // R18
    end else if (vpp_low && k != OP_BLANK) begin
      e = (k == OP_PROG) ? 16'h0018 : 16'h0028; // R17
    end
    return e;
  endfunction : start_err

  function automatic logic [15:0] op_len(input op_kind_t k, input logic [15:0] p,
                                         input logic [15:0] e, input logic [15:0] b);
    return (k == OP_PROG) ? p : ((k == OP_ERASE) ? e : b);
  endfunction : op_len
  wire [15:0] prog_len = 16'(PROG_CYCLES);
  wire [15:0] erase_len = 16'(ERASE_CYCLES);
  wire [15:0] blank_len = 16'(BLANK_CYCLES);

  always_comb begin
    op_kind_t k;
    logic [15:0] se;
    k = OP_NONE;
    se = '0;
    next_cmd_state = cmd_state;
    next_run_kind = run_kind;
    next_run_cnt = run_cnt;
    next_run_blk = run_blk;
    next_erase_parked = erase_parked;
    next_erase_left = erase_left;
    next_prog_parked = prog_parked;
    next_prog_left = prog_left;
    err_set = '0;
    err_clr = 1'b0;
    next_mode_status = mode_status;
    next_lock_bit = lock_bit;
    next_lockdown_bit = lockdown_bit;

    // Running operation
    if (running) begin
      if (vpp_low_s && run_kind != OP_BLANK) begin
        err_set = (run_kind == OP_PROG) ? 16'h0018 : 16'h0028; // R17
        next_run_kind = OP_NONE;
      end else if (run_cnt <= 16'h0001) begin
        next_run_kind = OP_NONE;
        if (run_kind == OP_PROG && REGION_ERR != 2'b00) begin
          err_set = {6'h00, REGION_ERR, 8'h10}; // R13
        end
        if (run_kind == OP_BLANK && !ARRAY_BLANK) begin
          err_set = erase_fail; // R8 R16
        end
      end else begin
        next_run_cnt = run_cnt - 16'h0001;
      end
    end

    if (wr) begin
      unique case (cmd_state)
        CMD_IDLE: begin
          if (is_setup) begin
            next_cmd_state = CMD_SETUP;
          end else if (cap_data == `CODE_READ_STATUS) begin
            next_mode_status[wr_part] = 1'b1; // R25
          end else if (cap_data == `CODE_READ_ARRAY) begin
            next_mode_status[wr_part] = 1'b0;
          end else if (cap_data == `CODE_CLEAR_STATUS) begin
            err_clr = 1'b1; // R10 R20
            next_mode_status[wr_part] = 1'b1; // R21
          end else if (cap_data == `CODE_SUSPEND && running && run_kind != OP_BLANK) begin
            next_run_kind = OP_NONE; // R6
            if (run_kind == OP_PROG) begin
              next_prog_parked = 1'b1;
              next_prog_left = next_run_cnt;
            end else begin
              next_erase_parked = 1'b1;
              next_erase_left = next_run_cnt;
            end
          end else if (cap_data == `CODE_RESUME && !running) begin
            if (prog_parked) begin
              next_prog_parked = 1'b0; // R7
              next_run_kind = OP_PROG;
              next_run_cnt = prog_left;
              next_run_blk = prog_blk;
            end else if (erase_parked) begin
              next_erase_parked = 1'b0; // R7
              next_run_kind = OP_ERASE;
              next_run_cnt = erase_left;
              next_run_blk = erase_blk;
            end
          end
        end
        CMD_SETUP: begin
          next_cmd_state = CMD_IDLE;
          if (setup_code == `CODE_LOCK_SETUP) begin
            if (cap_data == `CODE_LOCK) begin
              next_lock_bit[wr_blk] = 1'b1; // R3
            end else if (cap_data == `CODE_CONFIRM) begin
              if (!lockdown_bit[wr_blk]) begin
                next_lock_bit[wr_blk] = 1'b0; // R4
              end
            end else if (cap_data == `CODE_LOCKDOWN) begin
              next_lockdown_bit[wr_blk] = 1'b1; // R5
              next_lock_bit[wr_blk] = 1'b1;
            end else begin
              err_set = seq_err; // R23 R26
            end
          end else if (!is_confirm) begin
            err_set = seq_err; // R23 R26
          end else begin
            next_mode_status[wr_part] = 1'b1; // R1 R2 R8
            k = (setup_code == `CODE_ERASE_SETUP) ? OP_ERASE :
                ((setup_code == `CODE_BLANK_SETUP) ? OP_BLANK : OP_PROG);
            if (running || (k == OP_ERASE && erase_parked) || (k == OP_PROG && prog_parked)) begin
              err_set = seq_err;
            end else if (setup_code == `CODE_BUFFERED_FACTORY_PROGRAMMING_SETUP) begin
              se = start_err(OP_PROG, lock_bit[wr_blk], vpp_low_s);
              err_set = se;
              if (se == 16'h0000) begin
                next_cmd_state = CMD_BUFFERED_FACTORY_PROGRAMMING; // R1
              end
            end else begin
              se = start_err(k, lock_bit[wr_blk], vpp_low_s);
              err_set = se;
              if (se == 16'h0000) begin
                next_run_kind = k; // R2 R8
                next_run_cnt = op_len(k, prog_len, erase_len, blank_len);
                next_run_blk = wr_blk;
              end
            end
          end
        end
        CMD_BUFFERED_FACTORY_PROGRAMMING: begin
          if (cap_data == `CODE_SUSPEND && running) begin
            next_cmd_state = CMD_IDLE;
            next_run_kind = OP_NONE; // R6
            next_prog_parked = 1'b1;
            next_prog_left = next_run_cnt;
          end else if (wr_blk != setup_blk) begin
            next_cmd_state = CMD_IDLE;
          end else if (!running) begin
            next_run_kind = OP_PROG; // R1
            next_run_cnt = prog_len;
            next_run_blk = wr_blk;
          end
        end
        default: begin
          next_cmd_state = CMD_IDLE;
        end
      endcase
    end
    if (cmd_state == CMD_BUFFERED_FACTORY_PROGRAMMING && err_set != 16'h0000) begin
      next_cmd_state = CMD_IDLE;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cmd_state <= CMD_IDLE;
      setup_code <= '0;
      setup_blk <= '0;
    end else if (CLK_EN) begin
      cmd_state <= next_cmd_state;
      if (wr && cmd_state == CMD_IDLE) begin
        setup_code <= cap_data;
        setup_blk <= wr_blk;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      run_kind <= OP_NONE;
      run_cnt <= '0;
      run_blk <= '0;
      erase_parked <= 1'b0;
      erase_left <= '0;
      erase_blk <= '0;
      prog_parked <= 1'b0;
      prog_left <= '0;
      prog_blk <= '0;
    end else if (CLK_EN) begin
      run_kind <= next_run_kind;
      run_cnt <= next_run_cnt;
      run_blk <= next_run_blk;
      erase_parked <= next_erase_parked;
      erase_left <= next_erase_left;
      prog_parked <= next_prog_parked;
      prog_left <= next_prog_left;
      if (next_erase_parked && !erase_parked) begin
        erase_blk <= run_blk;
      end
      if (next_prog_parked && !prog_parked) begin
        prog_blk <= run_blk;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      err <= '0;
      mode_status <= '0;
      lock_bit <= '0;
      lockdown_bit <= '0;
    end else if (CLK_EN) begin
      err <= ((err & ~(err_clr ? `SR_ERROR_MASK : 16'h0000)) | err_set) & `SR_ERROR_MASK; // R10
      mode_status <= next_mode_status;
      lock_bit <= next_lock_bit;
      lockdown_bit <= next_lockdown_bit;
    end
  end

  // Status word as seen by a read of the addressed partition
  wire [2:0] rd_part = part_of(addr_s);
  wire buffered_factory_programming = cmd_state == CMD_BUFFERED_FACTORY_PROGRAMMING;
  wire busy = running || buffered_factory_programming;
  wire part_bit = buffered_factory_programming ? running : (running && part_of({run_blk, 17'h00000}) != rd_part); // R19
  wire [15:0] status_word = {6'h00, // R12
                             err[`SR_REGION_HI:`SR_REGION_LO], // R13
                             !busy, // R14
                             erase_parked, // R15
                             err[`SR_ERR_HI:`SR_ERR_LO], // R16
                             err[`SR_SUPPLY],
                             prog_parked, // R15
                             err[`SR_LOCK],
                             busy && part_bit}; // R19
  wire rd_act = !ce_n_s && !oe_n_s && we_n_s;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      DQ_OUT <= `STATUS_RESET; // R9
      DQ_OE <= 1'b0;
      READY <= 1'b1;
    end else if (CLK_EN) begin
      DQ_OUT <= mode_status[rd_part] ? status_word : ARRAY_RDATA; // R11
      DQ_OE <= rd_act;
      READY <= !busy;
    end
  end
endmodule : flash_command_status_unit
`default_nettype wire

// ### logic/pin_sync.sv
/*
  Three-stage synchroniser; output follows once stages two and three agree.
  Assumes a free clock and the released reset of the caller.
*/
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic clk_en, // Freezes state when low
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Filtered copy
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree;
  assign agree = ~(s2 ^ s3);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      q <= INIT;
    end else if (clk_en) begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q <= (s3 & agree) | (q & ~agree);
    end
  end
endmodule : pin_sync
`default_nettype wire

// ### shared/flash_cmd_params.svh
/*
  Constants of the flash command decoder and status word: command codes,
  status bit positions, reset value, address fields and operation lengths.
  Assumes a 16-bit data bus and a 24-bit word address with eight partitions.
*/
// Summary of operation
// [R1] Factory program: setup then confirm, status mode
// [R2] Block erase starts on confirm, status mode
// [R3] Lock setup plus lock confirm locks block
// [R4] Lock setup plus general confirm unlocks block; the code leaves a locked-down block locked
// [R5] Lock setup plus lock-down confirm sets lock-down
// [R6] Suspend code parks program or erase anywhere
// [R7] Resume code restarts; nested program resumes first
// [R8] Blank check setup and confirm checks block
// [R9] Status word is 16 bits, resets ready
// [R10] Error bits sticky until clear or reset
// [R11] Host reads status after status-read command
// [R12] Status bits fifteen to ten read zero
// [R13] Region result in bits nine, eight; sets four
// [R14] Bit seven is ready, low while busy
// [R15] Bits six and two show suspends
// [R16] Bits five, four encode operation result
// [R17] Low programming supply aborts, sets bit three
// [R18] Locked target aborts and sets bit one
// [R19] Bits seven and zero report partition activity
// [R20] Clear status ignores programming supply level
// [R21] Clear status sets addressed partition status mode
// [R22] Host clears status before resuming erase
// [R23] Write between two cycles is sequence error
// [R24] Commands are asynchronous writes, latched rising strobe
// [R25] Status-read command selects status read mode
// [R26] Unknown confirm aborts with sequence error
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

`define CODE_BUFFERED_FACTORY_PROGRAMMING_SETUP 16'h0080
`define CODE_ERASE_SETUP 16'h0020
`define CODE_LOCK_SETUP 16'h0060
`define CODE_BLANK_SETUP 16'h00bc
`define CODE_CONFIRM 16'h00d0
`define CODE_LOCK 16'h0001
`define CODE_LOCKDOWN 16'h002f
`define CODE_SUSPEND 16'h00b0
`define CODE_RESUME 16'h00d0
`define CODE_CLEAR_STATUS 16'h0050
`define CODE_READ_STATUS 16'h0070
`define CODE_READ_ARRAY 16'h00ff

`define STATUS_RESET 16'h0080
`define SR_REGION_HI 9
`define SR_REGION_LO 8
`define SR_READY 7
`define SR_ERASE_SUSP 6
`define SR_ERR_HI 5
`define SR_ERR_LO 4
`define SR_SUPPLY 3
`define SR_PROG_SUSP 2
`define SR_LOCK 1
`define SR_PART 0
`define SR_ERROR_MASK 16'h033a

`define ADDR_W 24
`define PART_HI 23
`define PART_LO 21
`define BLK_HI 23
`define BLK_LO 17

`define PROG_CYCLES 40
`define ERASE_CYCLES 400
`define BLANK_CYCLES 100

`endif

// ### shared/flash_cmd_pkg.sv
/*
  Types of the flash command decoder.
  Assumes nothing beyond the constants header.
*/
`default_nettype none
package flash_cmd_pkg;
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b00,
    CMD_SETUP = 2'b01,
    CMD_BUFFERED_FACTORY_PROGRAMMING = 2'b10
  } cmd_state_t;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00,
    OP_PROG = 2'b01,
    OP_ERASE = 2'b10,
    OP_BLANK = 2'b11
  } op_kind_t;
endpackage : flash_cmd_pkg
`default_nettype wire
